// ==== src/spc_serial_port.v ====
// serial port controller: asynchronous uart and clocked master/slave with control registers
`timescale 1ns/100ps
`default_nettype none
`include "spc_regs.vh"
// Overview of operation
// - clocked slave receive shifts on the external clock and flags a complete word
// - after the shift register empties, the buffered byte moves in and the flag rises
// - writing the holding buffer clears the buffer-empty flag
// - clock source bit: 1 master with own clock, 0 slave; ignored when asynchronous
// - nine-bit transmit select; ninth bit comes from its own field
// - transmit enable; in clocked mode continuous receive, or single receive as master, wins over it
// - mode bit: 1 clocked synchronous, 0 asynchronous
// - break bit sends start, twelve zeros, stop, then clears itself
// - high speed bit and wide divider bit choose the baud divider scaling
// - shift register status reads 1 when empty, resets to 1
// - port enable low holds the port in reset; enabled, pins switch themselves
// - nine-bit receive select; received ninth bit reads back read-only
// - single receive in clocked master mode runs one word, then clears itself
// - continuous receive runs until cleared and wins over single receive
// - address detect in nine-bit async mode keeps only words with ninth bit set
// - framing error reports the top received word's stop bit
// - overrun error set on a lost word, cleared with continuous receive
// - receiver idle flag low from start bit through reception, resets to 1
// - polarity selects idle level of async transmit line or of the clock
// - wake-up enable flags a falling receive edge, clears on next rising edge
// - auto-baud measures a 55h field, clears itself, flags timer overflow
module spc_serial_port #(
	parameter FIFO_AW = 1
) (
	// clock and reset
	input wire REF_CLK_I,
	input wire RST_I,
	// register port
	input wire [2:0] REG_ADDR_I,
	input wire [7:0] REG_WDATA_I,
	input wire REG_WR_I,
	input wire REG_RD_I,
	output reg [7:0] REG_RDATA_O,
	// transmit line or clock pin
	input wire TX_OR_CLK_PIN_I,
	output reg TX_OR_CLK_PIN_O,
	output reg TX_OR_CLK_PIN_OE_N_O,
	// receive line or data pin
	input wire RX_OR_DATA_PIN_I,
	output reg RX_OR_DATA_PIN_O,
	output reg RX_OR_DATA_PIN_OE_N_O,
	// completion flags toward wake and interrupt logic
	output wire RECEIVE_COMPLETE_O,
	output wire TX_BUFFER_EMPTY_O,
	output reg WAKE_EDGE_O
);
	localparam DEPTH = 1 << FIFO_AW;
	localparam PW = 23;
	localparam AW = 26;
	localparam RX_IDLE = 4'h1;
	localparam RX_START = 4'h2;
	localparam RX_DATA = 4'h4;
	localparam RX_STOP = 4'h8;

	reg clk_src_r, tnine_r, txon_r, sync_r, brk_r, hispd_r, tninth_r;
	reg porten_r, rnine_r, single_r, cont_r, addrdet_r, overrun_error_r;
	reg abovf_r, pol_r, wide_r, wake_r, auto_r;
	reg [15:0] div_r;
	reg [8:0] thr_r;
	reg thr_full_r;
	reg ck_s1_r, ck_s2_r, ck_s3_r, dt_s1_r, dt_s2_r, dt_s3_r;
	reg [13:0] tsr_r;
	reg [3:0] tcnt_r;
	reg tx_busy_r, brk_act_r, mck_r, dout_r;
	reg [PW-1:0] tx_tm_r, rx_tm_r;
	reg [3:0] rx_st_r;
	reg [8:0] rsr_r;
	reg [3:0] rcnt_r;
	reg push_r;
	reg [9:0] push_word_r;
	reg [9:0] fifo_mem [0:DEPTH-1];
	reg [FIFO_AW:0] wp_r, rp_r;
	reg wake_seen_r, ab_arm_r;
	reg [2:0] ab_edges_r;
	reg [AW-1:0] ab_cnt_r;
	reg [3:0] sh;

	wire hold = RST_I | ~porten_r;
	wire master = sync_r & clk_src_r;
	// single receive counts only for master
	wire rx_mode = cont_r | (single_r & master);
	wire tx_on = txon_r & ~(sync_r & rx_mode);
	wire [3:0] tbits = `SPC_DBITS + {3'h0, tnine_r};
	wire [3:0] rbits = `SPC_DBITS + {3'h0, rnine_r};
	// narrow divider ignores the high byte
	wire [15:0] div_eff = wide_r ? div_r : {8'h00, div_r[7:0]};
	wire [PW-1:0] period = ({7'h00, div_eff} + 23'h000001) << sh;
	wire [PW-1:0] period_m1 = period - 23'h000001;
	// compare with >= so a divider made smaller mid-count cannot strand a timer past its end
	wire tx_tick = (tx_tm_r >= period_m1);
	wire rx_tick = (rx_tm_r >= period_m1);
	wire rx_half = (rx_tm_r == {1'b0, period[PW-1:1]});
	wire dt_fall = dt_s3_r & ~dt_s2_r;
	wire dt_rise = ~dt_s3_r & dt_s2_r;
	wire mrun = master & ((tx_busy_r & ~rx_mode) | (rx_mode & ~overrun_error_r));
	// clock level relative to its idle level
	wire ck_act = ck_s2_r ^ pol_r;
	wire ck_prev = ck_s3_r ^ pol_r;
	wire ck_lead = master ? (mrun & tx_tick & ~mck_r) : (sync_r & ck_act & ~ck_prev);
	wire ck_trail = master ? (mrun & tx_tick & mck_r) : (sync_r & ~ck_act & ck_prev);
	wire load = ~hold & ~tx_busy_r & thr_full_r & tx_on;
	wire tx_line = tx_busy_r ? tsr_r[0] : `SPC_LINE_IDLE;
	wire brk_done = brk_act_r & ~sync_r & tx_tick & (tcnt_r == 4'h1);
	wire [FIFO_AW:0] fcount = wp_r - rp_r;
	wire fempty = (fcount == {(FIFO_AW+1){1'b0}});
	wire ffull = fcount[FIFO_AW];
	wire [9:0] ftop = fempty ? 10'h000 : fifo_mem[rp_r[FIFO_AW-1:0]];
	wire pop = REG_RD_I & (REG_ADDR_I == `SPC_A_DATA) & ~fempty;
	wire [8:0] rsr_in = {dt_s2_r, rsr_r[8:1]};
	wire [8:0] rword_in = rnine_r ? rsr_in : {1'b0, rsr_in[8:1]};
	wire [8:0] rword = rnine_r ? rsr_r : {1'b0, rsr_r[8:1]};
	wire ab_go = auto_r & ~sync_r;
	wire ab_ovf = ab_arm_r & (&ab_cnt_r);
	wire ab_done = ab_arm_r & dt_fall & (ab_edges_r == `SPC_AB_LAST) & ~ab_ovf;
	wire [AW-1:0] ab_q = ab_cnt_r >> (sh + `SPC_AB_SH);
	wire [15:0] ab_div = ab_q[15:0] - 16'h0001;
	wire wake_clr = wake_seen_r & dt_rise & ~sync_r;
	wire wr_tx = REG_WR_I & (REG_ADDR_I == `SPC_A_TXSC);
	wire wr_rx = REG_WR_I & (REG_ADDR_I == `SPC_A_RXSC);
	wire wr_baud = REG_WR_I & (REG_ADDR_I == `SPC_A_BAUD);

	// ninth bit and framing flag follow the top word
	assign RECEIVE_COMPLETE_O = ~fempty;
	// empty flag follows the holding buffer
	assign TX_BUFFER_EMPTY_O = ~thr_full_r;

	always @* begin
		if (sync_r) begin
			sh = `SPC_SH_SYNC;
		end else if (wide_r & hispd_r) begin
			sh = `SPC_SH_FAST;
		end else if (wide_r | hispd_r) begin
			sh = `SPC_SH_MID;
		end else begin
			sh = `SPC_SH_SLOW;
		end
	end

	// pins are asynchronous to the core clock, so levels use the second stage and edges the second and third
	always @(posedge REF_CLK_I) begin
		if (RST_I) begin
			ck_s1_r <= `SPC_LINE_IDLE;
			ck_s2_r <= `SPC_LINE_IDLE;
			ck_s3_r <= `SPC_LINE_IDLE;
			dt_s1_r <= `SPC_LINE_IDLE;
			dt_s2_r <= `SPC_LINE_IDLE;
			dt_s3_r <= `SPC_LINE_IDLE;
		end else begin
			ck_s1_r <= TX_OR_CLK_PIN_I;
			ck_s2_r <= ck_s1_r;
			ck_s3_r <= ck_s2_r;
			dt_s1_r <= RX_OR_DATA_PIN_I;
			dt_s2_r <= dt_s1_r;
			dt_s3_r <= dt_s2_r;
		end
	end

	// software registers; hardware clears come first so a write in the same cycle wins
	always @(posedge REF_CLK_I) begin
		if (RST_I) begin
			{clk_src_r, tnine_r, txon_r, sync_r, brk_r, hispd_r, tninth_r} <= 7'h00;
			{porten_r, rnine_r, single_r, cont_r, addrdet_r} <= 5'h00;
			{abovf_r, pol_r, wide_r, wake_r, auto_r} <= 5'h00;
			div_r <= {`SPC_RST_BYTE, `SPC_RST_BYTE};
			thr_r <= 9'h000;
			thr_full_r <= 1'b0;
		end else begin
			if (brk_done) begin
				brk_r <= 1'b0;
			end
			if (push_r & master & ~cont_r) begin
				single_r <= 1'b0;
			end
			if (wake_clr) begin
				wake_r <= 1'b0;
			end
			if (wr_baud & REG_WDATA_I[`SPC_B_AUTO]) begin
				abovf_r <= 1'b0;
			end
			if (ab_ovf) begin
				abovf_r <= 1'b1;
			end
			if (ab_done | ab_ovf) begin
				auto_r <= 1'b0;
			end
			if (ab_done) begin
				div_r <= ab_div;
			end
			// buffered byte moves on into the shift register
			if (load | ~porten_r) begin
				thr_full_r <= 1'b0;
			end
			if (wr_tx) begin
				clk_src_r <= REG_WDATA_I[`SPC_B_CLKSRC];
				tnine_r <= REG_WDATA_I[`SPC_B_TNINE];
				txon_r <= REG_WDATA_I[`SPC_B_TXON];
				sync_r <= REG_WDATA_I[`SPC_B_SYNCMODE];
				brk_r <= REG_WDATA_I[`SPC_B_BREAK];
				hispd_r <= REG_WDATA_I[`SPC_B_HISPD];
				tninth_r <= REG_WDATA_I[`SPC_B_TNINTH];
			end
			if (wr_rx) begin
				porten_r <= REG_WDATA_I[`SPC_B_PORTEN];
				rnine_r <= REG_WDATA_I[`SPC_B_RNINE];
				single_r <= REG_WDATA_I[`SPC_B_SINGLE];
				cont_r <= REG_WDATA_I[`SPC_B_CONT];
				addrdet_r <= REG_WDATA_I[`SPC_B_ADDRDET];
			end
			if (wr_baud) begin
				pol_r <= REG_WDATA_I[`SPC_B_POL];
				wide_r <= REG_WDATA_I[`SPC_B_WIDE];
				wake_r <= REG_WDATA_I[`SPC_B_WAKE];
				auto_r <= REG_WDATA_I[`SPC_B_AUTO];
			end
			if (REG_WR_I & (REG_ADDR_I == `SPC_A_DIVL)) begin
				div_r[7:0] <= REG_WDATA_I;
			end
			if (REG_WR_I & (REG_ADDR_I == `SPC_A_DIVH)) begin
				div_r[15:8] <= REG_WDATA_I;
			end
			// new character fills the holding buffer
			if (REG_WR_I & (REG_ADDR_I == `SPC_A_DATA)) begin
				thr_r <= {tninth_r, REG_WDATA_I};
				thr_full_r <= 1'b1;
			end
		end
	end

	// transmitter: async frames on its bit timer, clocked words on clock edges
	always @(posedge REF_CLK_I) begin
		if (hold) begin
			tx_busy_r <= 1'b0;
			brk_act_r <= 1'b0;
			tsr_r <= {14{1'b1}};
			tcnt_r <= 4'h0;
			tx_tm_r <= {PW{1'b0}};
			mck_r <= 1'b0;
			dout_r <= `SPC_LINE_IDLE;
		end else begin
			tx_tm_r <= (tx_tick | load) ? {PW{1'b0}} : tx_tm_r + 23'h000001;
			mck_r <= mrun ? (mck_r ^ tx_tick) : 1'b0;
			if (load) begin
				tx_busy_r <= 1'b1;
				if (sync_r) begin
					tsr_r <= {{5{1'b1}}, thr_r};
					tcnt_r <= tbits;
				end else if (brk_r) begin
					tsr_r <= `SPC_BRK_FRAME;
					tcnt_r <= `SPC_BRK_BITS;
					brk_act_r <= 1'b1;
				end else begin
					// ninth bit or stop in slot nine
					tsr_r <= {{4{1'b1}}, ~tnine_r | thr_r[8], thr_r[7:0], 1'b0};
					tcnt_r <= tbits + `SPC_FRAME_EXTRA;
				end
			end else if (tx_busy_r) begin
				if (~sync_r & tx_tick) begin
					tsr_r <= {1'b1, tsr_r[13:1]};
					tcnt_r <= tcnt_r - 4'h1;
					if (tcnt_r == 4'h1) begin
						tx_busy_r <= 1'b0;
						brk_act_r <= 1'b0;
					end
				end
				// data changes on the leading edge of the link clock
				if (sync_r & ck_lead) begin
					dout_r <= tsr_r[0];
					tsr_r <= {1'b1, tsr_r[13:1]};
				end
				if (sync_r & ck_trail) begin
					tcnt_r <= tcnt_r - 4'h1;
					if (tcnt_r == 4'h1) begin
						tx_busy_r <= 1'b0;
					end
				end
			end
		end
	end

	// receiver: clocked words on trailing edges, async frames sampled mid-bit
	always @(posedge REF_CLK_I) begin
		push_r <= 1'b0;
		if (hold) begin
			rx_st_r <= RX_IDLE;
			rx_tm_r <= {PW{1'b0}};
			rsr_r <= 9'h000;
			rcnt_r <= 4'h0;
			push_word_r <= 10'h000;
		end else if (sync_r) begin
			rx_st_r <= RX_IDLE;
			if (~rx_mode | overrun_error_r) begin
				rcnt_r <= 4'h0;
			end else if (ck_trail) begin
				// shift on the link clock, own as master or external as slave, flag the full word
				rsr_r <= rsr_in;
				if (rcnt_r == rbits - 4'h1) begin
					rcnt_r <= 4'h0;
					push_r <= 1'b1;
					push_word_r <= {1'b0, rword_in};
				end else begin
					rcnt_r <= rcnt_r + 4'h1;
				end
			end
		end else begin
			case (rx_st_r)
			RX_IDLE: begin
				rx_tm_r <= {PW{1'b0}};
				// continuous receive keeps the receiver armed
				if (cont_r & ~overrun_error_r & ~auto_r & dt_fall) begin
					rx_st_r <= RX_START;
				end
			end
			RX_START: begin
				rx_tm_r <= rx_tm_r + 23'h000001;
				if (rx_half) begin
					rx_tm_r <= {PW{1'b0}};
					rcnt_r <= 4'h0;
					rx_st_r <= dt_s2_r ? RX_IDLE : RX_DATA;
				end
			end
			RX_DATA: begin
				rx_tm_r <= rx_tick ? {PW{1'b0}} : rx_tm_r + 23'h000001;
				if (rx_tick) begin
					rsr_r <= rsr_in;
					rcnt_r <= rcnt_r + 4'h1;
					if (rcnt_r == rbits - 4'h1) begin
						rx_st_r <= RX_STOP;
					end
				end
			end
			RX_STOP: begin
				rx_tm_r <= rx_tick ? {PW{1'b0}} : rx_tm_r + 23'h000001;
				if (rx_tick) begin
					rx_st_r <= RX_IDLE;
					push_r <= ~(addrdet_r & rnine_r & ~rword[8]);
					// low stop bit is a framing error
					push_word_r <= {~dt_s2_r, rword};
				end
			end
			default: begin
				rx_st_r <= RX_IDLE;
			end
			endcase
		end
	end

	// two-word receive buffer; a word arriving while full is lost, not overwritten
	always @(posedge REF_CLK_I) begin
		if (hold) begin
			wp_r <= {(FIFO_AW+1){1'b0}};
			rp_r <= {(FIFO_AW+1){1'b0}};
			overrun_error_r <= 1'b0;
		end else begin
			if (push_r & ~ffull) begin
				fifo_mem[wp_r[FIFO_AW-1:0]] <= push_word_r;
				wp_r <= wp_r + {{FIFO_AW{1'b0}}, 1'b1};
			end
			if (pop) begin
				rp_r <= rp_r + {{FIFO_AW{1'b0}}, 1'b1};
			end
			// overrun set wins over its clear
			if (push_r & ffull) begin
				overrun_error_r <= 1'b1;
			end else if (~cont_r & (~single_r | pop)) begin
				overrun_error_r <= 1'b0;
			end
		end
	end

	// wake-up edge watch and auto-baud measurement, both asynchronous mode only
	always @(posedge REF_CLK_I) begin
		if (hold) begin
			WAKE_EDGE_O <= 1'b0;
			wake_seen_r <= 1'b0;
			ab_arm_r <= 1'b0;
			ab_edges_r <= 3'h0;
			ab_cnt_r <= {AW{1'b0}};
		end else begin
			// falling edge raises the wake pulse
			WAKE_EDGE_O <= wake_r & ~sync_r & dt_fall;
			if (~wake_r | sync_r) begin
				wake_seen_r <= 1'b0;
			end else if (dt_fall) begin
				wake_seen_r <= 1'b1;
			end
			// count from the start edge over four more falling edges
			if (~ab_go | ab_done | ab_ovf) begin
				ab_arm_r <= 1'b0;
			end else if (~ab_arm_r) begin
				if (dt_fall) begin
					ab_arm_r <= 1'b1;
					// start at one so the count spans the full eight bit times
					ab_cnt_r <= {{(AW-1){1'b0}}, 1'b1};
					ab_edges_r <= 3'h0;
				end
			end else begin
				ab_cnt_r <= ab_cnt_r + {{(AW-1){1'b0}}, 1'b1};
				if (dt_fall) begin
					ab_edges_r <= ab_edges_r + 3'h1;
				end
			end
		end
	end

	// pin drivers; output enables are active low
	always @(posedge REF_CLK_I) begin
		if (hold) begin
			TX_OR_CLK_PIN_O <= 1'b0;
			TX_OR_CLK_PIN_OE_N_O <= 1'b1;
			RX_OR_DATA_PIN_O <= 1'b0;
			RX_OR_DATA_PIN_OE_N_O <= 1'b1;
		// mode bit picks async line or clocked pins
		end else if (~sync_r) begin
			TX_OR_CLK_PIN_O <= tx_line ^ pol_r;
			TX_OR_CLK_PIN_OE_N_O <= 1'b0;
			RX_OR_DATA_PIN_O <= 1'b0;
			RX_OR_DATA_PIN_OE_N_O <= 1'b1;
		end else begin
			// slave releases the clock, receiver releases the data pin
			TX_OR_CLK_PIN_O <= mck_r ^ pol_r;
			TX_OR_CLK_PIN_OE_N_O <= ~master;
			RX_OR_DATA_PIN_O <= dout_r;
			RX_OR_DATA_PIN_OE_N_O <= ~tx_on;
		end
	end

	// read data stands only in the cycle after the read strobe
	always @(posedge REF_CLK_I) begin
		if (RST_I | ~REG_RD_I) begin
			REG_RDATA_O <= `SPC_RST_BYTE;
		end else begin
			case (REG_ADDR_I)
			`SPC_A_TXSC: REG_RDATA_O <= {clk_src_r, tnine_r, txon_r, sync_r, brk_r,
				hispd_r, ~tx_busy_r, tninth_r};
			`SPC_A_RXSC: REG_RDATA_O <= {porten_r, rnine_r, single_r, cont_r, addrdet_r,
				ftop[9], overrun_error_r, ftop[8]};
			// idle flag from the receive state
			`SPC_A_BAUD: REG_RDATA_O <= {abovf_r, rx_st_r == RX_IDLE, 1'b0, pol_r, wide_r,
				1'b0, wake_r, auto_r};
			`SPC_A_DATA: REG_RDATA_O <= ftop[7:0];
			`SPC_A_DIVL: REG_RDATA_O <= div_r[7:0];
			`SPC_A_DIVH: REG_RDATA_O <= div_r[15:8];
			`SPC_A_FLAG: REG_RDATA_O <= {6'h00, ~thr_full_r, ~fempty};
			default: REG_RDATA_O <= `SPC_RST_BYTE;
			endcase
		end
	end
endmodule // spc_serial_port
`default_nettype wire

// ==== src/spc_regs.vh ====
// register offsets, field positions, reset levels and timing constants of the serial port
`ifndef SPC_REGS_VH
`define SPC_REGS_VH
// register offsets on the plain register port
`define SPC_A_TXSC 3'h0
`define SPC_A_RXSC 3'h1
`define SPC_A_BAUD 3'h2
`define SPC_A_DATA 3'h3
`define SPC_A_DIVL 3'h4
`define SPC_A_DIVH 3'h5
`define SPC_A_FLAG 3'h6
// transmit status/control fields
`define SPC_B_CLKSRC 7
`define SPC_B_TNINE 6
`define SPC_B_TXON 5
`define SPC_B_SYNCMODE 4
`define SPC_B_BREAK 3
`define SPC_B_HISPD 2
`define SPC_B_TNINTH 0
// receive status/control fields
`define SPC_B_PORTEN 7
`define SPC_B_RNINE 6
`define SPC_B_SINGLE 5
`define SPC_B_CONT 4
`define SPC_B_ADDRDET 3
// baud control fields
`define SPC_B_POL 4
`define SPC_B_WIDE 3
`define SPC_B_WAKE 1
`define SPC_B_AUTO 0
// reset levels
`define SPC_RST_BYTE 8'h00
`define SPC_LINE_IDLE 1'b1
// divider scaling, as a shift of (n+1)
`define SPC_SH_SLOW 4'h6
`define SPC_SH_MID 4'h4
`define SPC_SH_FAST 4'h2
`define SPC_SH_SYNC 4'h1
// frame shapes
`define SPC_DBITS 4'h8
`define SPC_FRAME_EXTRA 4'h2
`define SPC_BRK_FRAME 14'h2000
`define SPC_BRK_BITS 4'he
// auto-baud: four more falling edges span eight bit times
`define SPC_AB_LAST 3'h3
`define SPC_AB_SH 4'h3
`endif

// ==== test/spc_serial_port_properties.sv ====
// pin and register-port checks for the serial port
`timescale 1ns/100ps
`default_nettype none
module spc_port_props (
	// clock and reset
	input wire logic REF_CLK_I,
	input wire logic RST_I,
	// register port
	input wire logic [2:0] REG_ADDR_I,
	input wire logic [7:0] REG_WDATA_I,
	input wire logic REG_WR_I,
	input wire logic REG_RD_I,
	input wire logic [7:0] REG_RDATA_O,
	// pins
	input wire logic TX_OR_CLK_PIN_I,
	input wire logic TX_OR_CLK_PIN_O,
	input wire logic TX_OR_CLK_PIN_OE_N_O,
	input wire logic RX_OR_DATA_PIN_I,
	input wire logic RX_OR_DATA_PIN_O,
	input wire logic RX_OR_DATA_PIN_OE_N_O,
	// flags
	input wire logic RECEIVE_COMPLETE_O,
	input wire logic TX_BUFFER_EMPTY_O,
	input wire logic WAKE_EDGE_O
);
	logic [7:0] txc_r;
	logic [7:0] rxc_r;
	wire logic slave_w;
	wire logic master_w;
	wire logic async_w;
	// only software-owned bits of these shadows are trusted; self-clearing bits drift
	always_ff @(posedge REF_CLK_I) begin
		if (RST_I) begin
			txc_r <= 8'h00;
			rxc_r <= 8'h00;
		end else if (REG_WR_I && REG_ADDR_I == 3'h0) begin
			txc_r <= REG_WDATA_I;
		end else if (REG_WR_I && REG_ADDR_I == 3'h1) begin
			rxc_r <= REG_WDATA_I;
		end
	end
	assign slave_w = rxc_r[7] && txc_r[4] && !txc_r[7];
	assign master_w = rxc_r[7] && txc_r[4] && txc_r[7];
	assign async_w = rxc_r[7] && !txc_r[4];
	default clocking cb @(posedge REF_CLK_I);
	endclocking
	default disable iff (RST_I);
	rd_idle_zero_a:
	assert property (!$past(REG_RD_I) |-> REG_RDATA_O == 8'h00)
		else $error("read data not zero outside answer cycle");
	rd_unmapped_a:
	assert property (REG_RD_I && REG_ADDR_I == 3'h7 |=> REG_RDATA_O == 8'h00)
		else $error("unmapped read not zero");
	flag_read_a:
	assert property (REG_RD_I && REG_ADDR_I == 3'h6 |=>
		REG_RDATA_O == {6'h00, $past(TX_BUFFER_EMPTY_O), $past(RECEIVE_COMPLETE_O)})
		else $error("flag register disagrees with flag pins");
	hold_write_a:
	assert property (rxc_r[7] && REG_WR_I && REG_ADDR_I == 3'h3 |=> !TX_BUFFER_EMPTY_O)
		else $error("buffer empty flag not cleared by data write");
	port_off_a:
	assert property (!rxc_r[7] && !$past(rxc_r[7]) |->
		TX_OR_CLK_PIN_OE_N_O && RX_OR_DATA_PIN_OE_N_O && !RECEIVE_COMPLETE_O)
		else $error("disabled port drives a pin or flags data");
	async_drive_a:
	assert property (async_w && $past(async_w) |-> !TX_OR_CLK_PIN_OE_N_O)
		else $error("async transmit line not driven");
	slave_clk_a:
	assert property (slave_w && $past(slave_w) |-> TX_OR_CLK_PIN_OE_N_O)
		else $error("slave drives the clock pin");
	master_clk_a:
	assert property (master_w && $past(master_w) |-> !TX_OR_CLK_PIN_OE_N_O)
		else $error("master does not drive the clock pin");
	rx_wins_a:
	assert property (rxc_r[4] && txc_r[4] && $past(rxc_r[4] && txc_r[4]) |->
		RX_OR_DATA_PIN_OE_N_O)
		else $error("data pin driven while receiving");
	wake_pulse_a:
	assert property (WAKE_EDGE_O |=> !WAKE_EDGE_O)
		else $error("wake pulse longer than one cycle");
	wake_async_a:
	assert property (WAKE_EDGE_O |-> !$past(txc_r[4]))
		else $error("wake pulse in clocked mode");
endmodule // spc_port_props
bind spc_serial_port spc_port_props u_spc_port_props (
	.REF_CLK_I(REF_CLK_I), .RST_I(RST_I), .REG_ADDR_I(REG_ADDR_I),
	.REG_WDATA_I(REG_WDATA_I), .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I),
	.REG_RDATA_O(REG_RDATA_O), .TX_OR_CLK_PIN_I(TX_OR_CLK_PIN_I),
	.TX_OR_CLK_PIN_O(TX_OR_CLK_PIN_O), .TX_OR_CLK_PIN_OE_N_O(TX_OR_CLK_PIN_OE_N_O),
	.RX_OR_DATA_PIN_I(RX_OR_DATA_PIN_I), .RX_OR_DATA_PIN_O(RX_OR_DATA_PIN_O),
	.RX_OR_DATA_PIN_OE_N_O(RX_OR_DATA_PIN_OE_N_O), .RECEIVE_COMPLETE_O(RECEIVE_COMPLETE_O),
	.TX_BUFFER_EMPTY_O(TX_BUFFER_EMPTY_O), .WAKE_EDGE_O(WAKE_EDGE_O)
);
`default_nettype wire

// ==== test/spc_link_partner.sv ====
// far-side model: async serial peer and clocked master
`timescale 1ns/100ps
`default_nettype none
module spc_link_partner #(
	parameter int BT = 16,
	parameter int HALF = 8
) (
	input wire logic clk_i,
	input wire logic tx_line_i,
	input wire logic data_line_i,
	output logic ck_o,
	output logic dt_o
);
	initial begin
		ck_o = 1'b0;
		dt_o = 1'b1;
	end
	task automatic async_send(input logic [8:0] d, input int nb, input logic stop);
		dt_o <= 1'b0;
		repeat (BT) @(posedge clk_i);
		for (int i = 0; i < nb; i++) begin
			dt_o <= d[i];
			repeat (BT) @(posedge clk_i);
		end
		dt_o <= stop;
		repeat (BT) @(posedge clk_i);
		dt_o <= 1'b1;
		repeat (2 * BT) @(posedge clk_i);
	endtask
	task automatic wait_low();
		int n;
		n = 0;
		while (tx_line_i !== 1'b0 && n < 4000) begin
			@(posedge clk_i);
			#1;
			n++;
		end
	endtask
	task automatic async_recv(input int nb, output logic [8:0] q, output logic stop);
		q = 9'h000;
		wait_low();
		repeat (BT / 2) @(posedge clk_i);
		for (int i = 0; i < nb; i++) begin
			repeat (BT) @(posedge clk_i);
			q[i] = tx_line_i;
		end
		repeat (BT) @(posedge clk_i);
		stop = tx_line_i;
	endtask
	task automatic low_run(output int n);
		n = 0;
		wait_low();
		while (tx_line_i === 1'b0 && n < 4000) begin
			n++;
			@(posedge clk_i);
			#1;
		end
	endtask
	// one clock per bit, data moves on leading edge
	task automatic sync_frame(input logic [8:0] d, input int nb, output logic [8:0] q);
		q = 9'h000;
		for (int i = 0; i < nb; i++) begin
			ck_o <= 1'b1;
			dt_o <= d[i];
			repeat (HALF) @(posedge clk_i);
			ck_o <= 1'b0;
			q[i] = data_line_i;
			repeat (HALF) @(posedge clk_i);
		end
		// a released line must not keep showing the last bit
		dt_o <= ~dt_o;
	endtask
endmodule // spc_link_partner
`default_nettype wire

// ==== test/spc_serial_port_tb_top.sv ====
// self-checking bench for the serial port controller
`timescale 1ns/100ps
`default_nettype none
module spc_serial_port_tb_top;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [2:0] addr = 3'h0;
	logic [7:0] wdata = 8'h00;
	logic wr_s = 1'b0;
	logic rd_s = 1'b0;
	wire logic [7:0] rdata;
	wire logic tx_o, tx_oe_n, rx_o, rx_oe_n, rc, txe, wake, ck_p, dt_p, tx_w, rx_w;
	logic [8:0] q;
	logic s;
	logic prev;
	logic got;
	int n;
	int n_fail = 0;
	int num_checks = 0;
	always #2.5 clk = ~clk;
	assign tx_w = tx_oe_n ? ck_p : tx_o;
	assign rx_w = rx_oe_n ? dt_p : rx_o;
	spc_serial_port #(.FIFO_AW(1)) u_spc_serial_port (
		.REF_CLK_I(clk), .RST_I(rst), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
		.REG_WR_I(wr_s), .REG_RD_I(rd_s), .REG_RDATA_O(rdata),
		.TX_OR_CLK_PIN_I(tx_w), .TX_OR_CLK_PIN_O(tx_o), .TX_OR_CLK_PIN_OE_N_O(tx_oe_n),
		.RX_OR_DATA_PIN_I(rx_w), .RX_OR_DATA_PIN_O(rx_o), .RX_OR_DATA_PIN_OE_N_O(rx_oe_n),
		.RECEIVE_COMPLETE_O(rc), .TX_BUFFER_EMPTY_O(txe), .WAKE_EDGE_O(wake)
	);
	spc_link_partner #(.BT(16), .HALF(8)) u_spc_link_partner (
		.clk_i(clk), .tx_line_i(tx_w), .data_line_i(rx_w), .ck_o(ck_p), .dt_o(dt_p)
	);
	task automatic end_sim();
		if (n_fail == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		num_checks++;
		if (g !== e) begin
			$display("ERROR %s expected %h seen %h", nm, e, g);
			n_fail++;
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		wr_s <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask
	task automatic rchk(input logic [2:0] a, input logic [7:0] e);
		@(posedge clk);
		rd_s <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd_s <= 1'b0;
		#1;
		chk($sformatf("register %0d", a), {8'h00, e}, {8'h00, rdata});
	endtask
	initial begin
		#100000;
		n_fail++;
		end_sim();
	end
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		rchk(3'h0, 8'h02);
		rchk(3'h1, 8'h00);
		rchk(3'h2, 8'h40);
		rchk(3'h6, 8'h02);
		rchk(3'h7, 8'h00);
		// async, wide divider, fast: (3+1)<<2 = 16 cycles a bit
		wr(3'h4, 8'h03);
		wr(3'h2, 8'h08);
		wr(3'h1, 8'h80);
		wr(3'h0, 8'h24);
		wr(3'h3, 8'ha5);
		u_spc_link_partner.async_recv(8, q, s);
		chk("tx 8-bit", 16'h00a5, {7'h00, q});
		chk("tx stop", 16'h0001, {15'h0, s});
		wr(3'h0, 8'h65);
		wr(3'h3, 8'h3c);
		u_spc_link_partner.async_recv(9, q, s);
		chk("tx 9-bit", 16'h013c, {7'h00, q});
		wr(3'h0, 8'h2c);
		wr(3'h3, 8'h00);
		u_spc_link_partner.low_run(n);
		chk("break low", 16'h00d0, 16'(n));
		repeat (40) @(posedge clk);
		rchk(3'h0, 8'h26);
		wr(3'h2, 8'h18);
		repeat (4) @(posedge clk);
		chk("idle level", 16'h0000, {15'h0, tx_w});
		wr(3'h2, 8'h08);
		wr(3'h1, 8'h90);
		fork
			u_spc_link_partner.async_send(9'h05a, 8, 1'b1);
			begin
				repeat (48) @(posedge clk);
				rchk(3'h2, 8'h08);
			end
		join
		chk("rx complete", 16'h0001, {15'h0, rc});
		rchk(3'h1, 8'h90);
		rchk(3'h6, 8'h03);
		rchk(3'h3, 8'h5a);
		u_spc_link_partner.async_send(9'h0c3, 8, 1'b0);
		rchk(3'h1, 8'h94);
		rchk(3'h3, 8'hc3);
		wr(3'h1, 8'hd8);
		u_spc_link_partner.async_send(9'h011, 9, 1'b1);
		u_spc_link_partner.async_send(9'h122, 9, 1'b1);
		rchk(3'h1, 8'hd9);
		rchk(3'h3, 8'h22);
		chk("rx empty", 16'h0000, {15'h0, rc});
		wr(3'h1, 8'h90);
		for (int i = 1; i <= 3; i++) begin
			u_spc_link_partner.async_send(9'(i), 8, 1'b1);
		end
		rchk(3'h1, 8'h92);
		wr(3'h1, 8'h80);
		rchk(3'h1, 8'h80);
		rchk(3'h3, 8'h01);
		rchk(3'h3, 8'h02);
		wr(3'h2, 8'h0a);
		got = 1'b0;
		fork
			u_spc_link_partner.async_send(9'h000, 0, 1'b1);
			repeat (40) begin
				@(posedge clk);
				#1;
				got = got | (wake === 1'b1);
			end
		join
		chk("wake pulse", 16'h0001, {15'h0, got});
		rchk(3'h2, 8'h48);
		// auto-baud on a 55h field sent at 16 cycles a bit with fast scaling
		wr(3'h4, 8'h01);
		wr(3'h2, 8'h09);
		u_spc_link_partner.async_send(9'h055, 8, 1'b1);
		rchk(3'h2, 8'h48);
		rchk(3'h4, 8'h03);
		rchk(3'h5, 8'h00);
		// clocked master single receive: half period 2*(3+1)
		wr(3'h0, 8'h90);
		wr(3'h1, 8'ha0);
		n = 0;
		prev = tx_w;
		repeat (300) begin
			@(posedge clk);
			#1;
			n += int'(tx_w === 1'b1 && prev === 1'b0);
			prev = tx_w;
		end
		chk("master clocks", 16'h0008, 16'(n));
		rchk(3'h1, 8'h80);
		rchk(3'h3, 8'hff);
		wr(3'h0, 8'h10);
		wr(3'h1, 8'h90);
		chk("rx empty", 16'h0000, {15'h0, rc});
		u_spc_link_partner.sync_frame(9'h096, 8, q);
		repeat (8) @(posedge clk);
		chk("slave rx flag", 16'h0001, {15'h0, rc});
		rchk(3'h3, 8'h96);
		wr(3'h1, 8'h80);
		wr(3'h0, 8'h30);
		wr(3'h3, 8'h5a);
		repeat (4) @(posedge clk);
		wr(3'h3, 8'hc3);
		#1;
		chk("tx empty", 16'h0000, {15'h0, txe});
		rchk(3'h0, 8'h30);
		u_spc_link_partner.sync_frame(9'h000, 8, q);
		chk("slave tx 1", 16'h005a, {7'h00, q});
		repeat (8) @(posedge clk);
		chk("tx empty", 16'h0001, {15'h0, txe});
		u_spc_link_partner.sync_frame(9'h000, 8, q);
		chk("slave tx 2", 16'h00c3, {7'h00, q});
		repeat (8) @(posedge clk);
		rchk(3'h0, 8'h32);
		end_sim();
	end
endmodule // spc_serial_port_tb_top
`default_nettype wire
